/* hw/twzs_pkg.sv */
// Functional notes
// - a table write stores the table latch byte in the holding register picked by pointer bits 2..0.
// - the table pointer is 21 bits wide and addresses program memory bytewise over two megabytes.
// - pointer bit 0 picks the low byte of a program word when 0 and the high byte when 1.
// - the table write mode field means 0 no change, 1 post-increment, 2 post-decrement, 3 pre-increment.
// - the skip instruction, opcode 0110 011a, discards the fetched next instruction when the operand is zero.
// - a taken skip runs a no-operation cycle in place of the discarded word, two cycles in all.
// - a taken skip over a two-word instruction takes three cycles, one no-operation per discarded word.
// - the bank bit picks the access bank when 0 and the bank select register bank when 1, address up to 255.
// - bank bit 0 with the extended set on and address up to 95 uses indexed literal offset addressing.
// - the extended set enable comes from a configuration bit fixed at programming time.
package twzs_pkg;
	localparam int PTR_W = 21;
	localparam int HOLD_N = 8;
	localparam int HOLD_SEL_W = 3;
	localparam logic [PTR_W-1:0] PTR_RESET = 21'h000000;
	localparam logic [7:0] BYTE_RESET = 8'hFF;
	localparam logic [15:0] TABWR_MASK = 16'hFFFC;
	localparam logic [15:0] TABWR_CODE = 16'h000C;
	localparam logic [15:0] SKIPZ_MASK = 16'hFE00;
	localparam logic [15:0] SKIPZ_CODE = 16'h6600;
	localparam int BANK_BIT = 8;
	localparam logic [7:0] INDEXED_MAX = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_POSTINC = 2'h1;
	localparam logic [1:0] MODE_POSTDEC = 2'h2;
	localparam logic [1:0] MODE_PREINC = 2'h3;
	typedef enum logic [1:0] {TWZS_IDLE, TWZS_TBLWR, TWZS_SKIP1, TWZS_SKIP2} twzs_state_t;
endpackage

/* hw/twzs_hold_regs.sv */
`timescale 1ns/10ps
module twzs_hold_regs #(
	parameter int N = twzs_pkg::HOLD_N,
	parameter int SEL_W = twzs_pkg::HOLD_SEL_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// staging write
	input wire logic wrEn,
	input wire logic [SEL_W-1:0] wrSel,
	input wire logic [7:0] wrData,
	// contents toward the programming sequencer
	output logic [N*8-1:0] holdBytes
);
	logic [7:0] holdMem [N];
	logic [7:0] next_holdMem [N];

	always_comb begin
		for (int i = 0; i < N; i++) begin
			next_holdMem[i] = holdMem[i];
		end
		if (wrEn) begin
			next_holdMem[wrSel] = wrData;
		end
	end

	// staging only: memory itself is never written from here
	always_ff @(posedge mclk) begin
		for (int i = 0; i < N; i++) begin
			if (!rst_n) begin
				holdMem[i] <= twzs_pkg::BYTE_RESET;
			end else begin
				holdMem[i] <= next_holdMem[i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gOut
			assign holdBytes[g*8 +: 8] = holdMem[g];
		end
	endgenerate
endmodule

/* hw/twzs_exec.sv */
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
module twzs_exec #(
	parameter int PTR_W = twzs_pkg::PTR_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// decode stage, one pulse per instruction cycle slot
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire logic nextIsTwoWord,
	// state from the rest of the core
	input wire logic [7:0] tableLatch,
	input wire logic [3:0] bankSelectRegister,
	input wire logic extendedSetEnableBit,
	input wire logic [7:0] fileData,
	input wire logic progTrigger,
	// table pointer write from software path
	input wire logic ptrLoad,
	input wire logic [PTR_W-1:0] ptrLoadValue,
	// operand address toward data memory
	output logic [11:0] fileAddr,
	output logic fileIndexed,
	output logic [7:0] fileOffset,
	// pipeline control
	output logic busy,
	output logic flushFetch,
	output logic nopIssue,
	output logic statusWriteEn,
	// table state
	output logic [PTR_W-1:0] tablePointer,
	output logic byteHigh,
	output logic [twzs_pkg::HOLD_N*8-1:0] holdBytes,
	output logic progStart
);
	twzs_pkg::twzs_state_t state, next_state;
	logic [PTR_W-1:0] next_tablePointer;
	logic [1:0] mode, next_mode;
	logic [11:0] next_fileAddr;
	logic next_fileIndexed;
	logic [7:0] next_fileOffset;
	logic twoWord, next_twoWord;
	logic holdWr;
	logic isTableWrite, isSkip;
	logic next_progStart;

	assign isTableWrite = instrValid && state == twzs_pkg::TWZS_IDLE &&
		(instrWord & twzs_pkg::TABWR_MASK) == twzs_pkg::TABWR_CODE;
	assign isSkip = instrValid && state == twzs_pkg::TWZS_IDLE &&
		(instrWord & twzs_pkg::SKIPZ_MASK) == twzs_pkg::SKIPZ_CODE;
	assign busy = state != twzs_pkg::TWZS_IDLE;
	assign statusWriteEn = 1'b0;
	assign byteHigh = tablePointer[0];

	////////////////////////////////////////////////////////////////////////////
	// operand address: decoded in cycle 1, file data valid in cycle 2
	always_comb begin
		next_fileAddr = fileAddr;
		next_fileIndexed = fileIndexed;
		next_fileOffset = fileOffset;
		if (isSkip) begin
			next_fileOffset = instrWord[7:0];
			next_fileIndexed = !instrWord[twzs_pkg::BANK_BIT] && extendedSetEnableBit &&
				instrWord[7:0] <= twzs_pkg::INDEXED_MAX;
			if (instrWord[twzs_pkg::BANK_BIT]) begin
				next_fileAddr = {bankSelectRegister, instrWord[7:0]};
			end else if (instrWord[7:0] < twzs_pkg::ACCESS_SPLIT) begin
				next_fileAddr = {4'h0, instrWord[7:0]};
			end else begin
				next_fileAddr = {twzs_pkg::ACCESS_HI_BANK, instrWord[7:0]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb begin
		next_state = state;
		next_tablePointer = tablePointer;
		next_mode = mode;
		next_twoWord = twoWord;
		holdWr = 1'b0;
		flushFetch = 1'b0;
		nopIssue = 1'b0;
		// a trigger while busy is dropped; software must raise it again
		next_progStart = progTrigger && state == twzs_pkg::TWZS_IDLE;
		// a load in the same cycle as an instruction update loses to it
		if (ptrLoad) begin
			next_tablePointer = ptrLoadValue;
		end
		case (state)
			twzs_pkg::TWZS_IDLE: begin
				if (isTableWrite) begin
					next_mode = instrWord[1:0];
					next_state = twzs_pkg::TWZS_TBLWR;
					if (instrWord[1:0] == twzs_pkg::MODE_PREINC) begin
						next_tablePointer = tablePointer + 1'b1;
					end
				end else if (isSkip) begin
					next_twoWord = nextIsTwoWord;
					next_state = twzs_pkg::TWZS_SKIP1;
				end
			end
			twzs_pkg::TWZS_TBLWR: begin
				holdWr = 1'b1;
				next_state = twzs_pkg::TWZS_IDLE;
				if (mode == twzs_pkg::MODE_POSTINC) begin
					next_tablePointer = tablePointer + 1'b1;
				end else if (mode == twzs_pkg::MODE_POSTDEC) begin
					next_tablePointer = tablePointer - 1'b1;
				end
			end
			twzs_pkg::TWZS_SKIP1: begin
				// file data must already stand here; slow memory gets no wait
				if (fileData == 8'h00) begin
					flushFetch = 1'b1;
					nopIssue = 1'b1;
					next_state = twoWord ? twzs_pkg::TWZS_SKIP2 : twzs_pkg::TWZS_IDLE;
				end else begin
					next_state = twzs_pkg::TWZS_IDLE;
				end
			end
			default: begin
				nopIssue = 1'b1;
				flushFetch = 1'b1;
				next_state = twzs_pkg::TWZS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= twzs_pkg::TWZS_IDLE;
			tablePointer <= twzs_pkg::PTR_RESET;
			mode <= twzs_pkg::MODE_NONE;
			twoWord <= 1'b0;
			fileAddr <= 12'h000;
			fileIndexed <= 1'b0;
			fileOffset <= 8'h00;
			progStart <= 1'b0;
		end else begin
			state <= next_state;
			tablePointer <= next_tablePointer;
			mode <= next_mode;
			twoWord <= next_twoWord;
			fileAddr <= next_fileAddr;
			fileIndexed <= next_fileIndexed;
			fileOffset <= next_fileOffset;
			progStart <= next_progStart;
		end
	end

	twzs_hold_regs #(
		.N(twzs_pkg::HOLD_N),
		.SEL_W(twzs_pkg::HOLD_SEL_W)
	) uHold (
		.mclk(mclk),
		.rst_n(rst_n),
		.wrEn(holdWr),
		.wrSel(tablePointer[twzs_pkg::HOLD_SEL_W-1:0]),
		.wrData(tableLatch),
		.holdBytes(holdBytes)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_table_write_cycles: assert property (@(posedge mclk) disable iff (!rst_n)
		isTableWrite |=> state == twzs_pkg::TWZS_TBLWR ##1 state == twzs_pkg::TWZS_IDLE)
		else $error("table write not two cycles");
	a_post_inc: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_TBLWR && mode == twzs_pkg::MODE_POSTINC && !ptrLoad
		|=> tablePointer == $past(tablePointer) + 1'b1)
		else $error("post increment wrong");
	a_post_dec: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_TBLWR && mode == twzs_pkg::MODE_POSTDEC && !ptrLoad
		|=> tablePointer == $past(tablePointer) - 1'b1)
		else $error("post decrement wrong");
	a_pre_inc: assert property (@(posedge mclk) disable iff (!rst_n)
		isTableWrite && instrWord[1:0] == twzs_pkg::MODE_PREINC
		|=> tablePointer == $past(tablePointer) + 1'b1)
		else $error("pre increment wrong");
	a_ptr_unchanged: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_TBLWR && mode == twzs_pkg::MODE_NONE && !ptrLoad
		|=> tablePointer == $past(tablePointer))
		else $error("pointer moved without update mode");
	a_hold_write: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_TBLWR
		|=> holdBytes[$past(tablePointer[2:0])*8 +: 8] == $past(tableLatch))
		else $error("holding byte not written");
	a_hold_stable: assert property (@(posedge mclk) disable iff (!rst_n)
		state != twzs_pkg::TWZS_TBLWR |=> holdBytes == $past(holdBytes))
		else $error("holding byte changed outside table write");
	a_prog_start: assert property (@(posedge mclk) disable iff (!rst_n)
		progTrigger && !busy |=> progStart)
		else $error("programming start missing");
	a_skip_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_SKIP1 && fileData == 8'h00 |-> flushFetch && nopIssue)
		else $error("zero operand did not skip");
	a_skip_nonzero: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_SKIP1 && fileData != 8'h00 |-> !nopIssue ##1 !busy)
		else $error("nonzero operand skipped");
	a_skip_one_word: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_SKIP1 && fileData == 8'h00 && !twoWord |=> !busy)
		else $error("one word skip length wrong");
	a_skip_two_word: assert property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_SKIP1 && fileData == 8'h00 && twoWord
		|=> nopIssue ##1 !busy)
		else $error("two word skip length wrong");
	a_bank_sel: assert property (@(posedge mclk) disable iff (!rst_n)
		isSkip && instrWord[8] |=> fileAddr == {$past(bankSelectRegister), $past(instrWord[7:0])})
		else $error("banked address wrong");
	a_access_bank: assert property (@(posedge mclk) disable iff (!rst_n)
		isSkip && !instrWord[8] |=> fileAddr ==
		{($past(instrWord[7:0]) < 8'h60) ? 4'h0 : 4'hF, $past(instrWord[7:0])})
		else $error("access bank address wrong");
	a_indexed_mode: assert property (@(posedge mclk) disable iff (!rst_n)
		isSkip |=> fileIndexed == (!$past(instrWord[8]) && $past(extendedSetEnableBit)
		&& $past(instrWord[7:0]) <= 8'h5F))
		else $error("indexed mode wrong");
	a_no_status: assert property (@(posedge mclk) disable iff (!rst_n) busy |-> !statusWriteEn)
		else $error("status written");

	////////////////////////////////////////////////////////////////////////////
	// main scenarios worth seeing in a run
	c_table_write: cover property (@(posedge mclk) disable iff (!rst_n) isTableWrite);
	c_skip_one: cover property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_SKIP1 && nopIssue && !twoWord);
	c_skip_two: cover property (@(posedge mclk) disable iff (!rst_n) state == twzs_pkg::TWZS_SKIP2);
	c_preinc: cover property (@(posedge mclk) disable iff (!rst_n)
		isTableWrite && instrWord[1:0] == 2'h3);
	c_post_dec: cover property (@(posedge mclk) disable iff (!rst_n)
		state == twzs_pkg::TWZS_TBLWR && mode == twzs_pkg::MODE_POSTDEC);
endmodule

/* bench/twzs_exec_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errors++; $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module twzs_exec_tb;
	logic mclk = 0, rst_n = 0, instrValid = 0, nextIsTwoWord = 0, extendedSetEnableBit = 0;
	logic progTrigger = 0, ptrLoad = 0, statusWriteEn, busy, flushFetch, nopIssue;
	logic fileIndexed, byteHigh, progStart;
	logic [15:0] instrWord = 16'h0000;
	logic [7:0] tableLatch = 8'h00, fileData = 8'h00, fileOffset;
	logic [3:0] bankSelectRegister = 4'h0;
	logic [20:0] ptrLoadValue = 21'h000000, tablePointer;
	logic [11:0] fileAddr;
	logic [63:0] holdBytes, hold = {64{1'b1}};
	int errors = 0, checkCount = 0, cycles = 0;
	always #2.5 mclk = ~mclk;
	twzs_exec u_twzs_exec (.mclk(mclk), .rst_n(rst_n), .instrValid(instrValid),
		.instrWord(instrWord), .nextIsTwoWord(nextIsTwoWord), .tableLatch(tableLatch),
		.bankSelectRegister(bankSelectRegister), .extendedSetEnableBit(extendedSetEnableBit),
		.fileData(fileData), .progTrigger(progTrigger), .ptrLoad(ptrLoad),
		.ptrLoadValue(ptrLoadValue), .fileAddr(fileAddr), .fileIndexed(fileIndexed),
		.fileOffset(fileOffset), .busy(busy), .flushFetch(flushFetch), .nopIssue(nopIssue),
		.statusWriteEn(statusWriteEn), .tablePointer(tablePointer), .byteHigh(byteHigh),
		.holdBytes(holdBytes), .progStart(progStart));
	////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d errors %0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait, so a stuck busy cannot hang the run
	task automatic waitIdle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 8) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`CHK(busy, 1'b0)
		`CHK(statusWriteEn, 1'b0)
	endtask
	// poke presents a second write while busy, which must be ignored
	task automatic tw(input logic [1:0] mode, input logic [20:0] p, input logic [7:0] lat,
			input logic poke);
		logic [20:0] e, f;
		e = (mode == 2'h3) ? p + 21'h1 : p;
		f = (mode == 2'h0) ? p : (mode == 2'h2) ? p - 21'h1 : p + 21'h1;
		@(posedge mclk);
		ptrLoad <= 1'b1;
		ptrLoadValue <= p;
		tableLatch <= lat;
		@(posedge mclk);
		ptrLoad <= 1'b0;
		instrValid <= 1'b1;
		instrWord <= 16'h000C | {14'h0000, mode};
		@(posedge mclk);
		instrValid <= poke;
		instrWord <= 16'h000D;
		#1 `CHK(busy, 1'b1)
		@(posedge mclk);
		instrValid <= 1'b0;
		#1;
		hold[e[2:0]*8 +: 8] = lat;
		`CHK(holdBytes, hold)
		`CHK(tablePointer, f)
		`CHK(byteHigh, f[0])
		waitIdle();
	endtask
	task automatic sk(input logic a, input logic [7:0] f, input logic [3:0] bank, input logic x,
			input logic [7:0] d, input logic two);
		logic z, ix;
		z = (d == 8'h00);
		ix = ~a & x & (f <= 8'h5F);
		@(posedge mclk);
		instrValid <= 1'b1;
		instrWord <= {7'b0110011, a, f};
		nextIsTwoWord <= two;
		bankSelectRegister <= bank;
		extendedSetEnableBit <= x;
		@(posedge mclk);
		instrValid <= 1'b0;
		fileData <= d;
		#1 `CHK(flushFetch, z)
		`CHK(nopIssue, z)
		`CHK(fileIndexed, ix)
		if (ix) `CHK(fileOffset, f)
		else if (a) `CHK(fileAddr, {bank, f})
		else `CHK(fileAddr, {(f < 8'h60) ? 4'h0 : 4'hF, f})
		@(posedge mclk);
		#1 `CHK(nopIssue, z & two)
		`CHK(flushFetch, z & two)
		waitIdle();
	endtask
	// a foreign opcode rides along; staging must survive the programming trigger
	task automatic prog;
		@(posedge mclk);
		progTrigger <= 1'b1;
		instrValid <= 1'b1;
		instrWord <= 16'h0008;
		@(posedge mclk);
		progTrigger <= 1'b0;
		instrValid <= 1'b0;
		#1 `CHK(progStart, 1'b1)
		`CHK(busy, 1'b0)
		@(posedge mclk);
		#1 `CHK(progStart, 1'b0)
		`CHK(holdBytes, hold)
	endtask
	////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		#1 `CHK(holdBytes, hold)
		`CHK(tablePointer, 21'h000000)
		for (int i = 0; i < 8; i++) tw(2'h1, 21'h000010 + i[20:0], 8'h11 * i[7:0], 1'b0);
		tw(2'h0, 21'h00A356, 8'h55, 1'b0);
		tw(2'h1, 21'h00A356, 8'h55, 1'b1);
		tw(2'h3, 21'h01389A, 8'h34, 1'b0);
		tw(2'h2, 21'h000000, 8'hA5, 1'b0);
		tw(2'h1, 21'h1FFFFF, 8'h3C, 1'b0);
		sk(1'b1, 8'h12, 4'h3, 1'b0, 8'h00, 1'b0);
		sk(1'b1, 8'hF0, 4'hA, 1'b1, 8'h07, 1'b1);
		sk(1'b0, 8'h20, 4'h5, 1'b0, 8'h00, 1'b1);
		sk(1'b0, 8'h5F, 4'h5, 1'b1, 8'h00, 1'b0);
		sk(1'b0, 8'h60, 4'h5, 1'b1, 8'h00, 1'b1);
		sk(1'b0, 8'hFF, 4'h5, 1'b0, 8'h80, 1'b0);
		prog();
		conclude();
	end
endmodule
